// *** hw/tmr_core.sv ***
// tmr_core: temperature monitor register set behind a two-wire serial slave port
// assumes: serial clock/data arrive unsynchronised; conversion results come from
// same-clock logic as a one-cycle conv_done pulse with both zone values
//
// Behaviour
// - command byte low bits pick temp, config, hysteresis or setpoint register.
// - temperature register is read-only; data sits in bits 15..7.
// - temperature resets to zero, updated by each finished conversion except while powered down.
// - hysteresis is 9-bit read/write, resets to 0x096.
// - setpoint is 9-bit read/write, resets to 0x0a0.
// - 9-bit values travel as two bytes, left justified.
// - config bits: flag, mask, zone, depth[1:0], polarity, mode, power down.
// - event flag reports a qualified event; host writes cannot set it.
// - mask zero enables alert, one disables it.
// - mask set keeps alert pin released regardless of polarity.
// - zone bit picks remote (1) or internal (0) result.
// - depth codes 00,01,10,11 mean 1,2,4,6 consecutive conversions.
// - polarity one is active high alert, zero active low.
// - mode one is interrupt behaviour, zero comparator behaviour.
// - power down bit stops conversions; config resets to zero.
// - flag sets once depth conversions see temp below hysteresis or above setpoint; in interrupt mode the two alternate, above setpoint first.
// - crossing counts only after depth consecutive qualifying conversions.
// - config read clears flag; many events show as one.
// - interrupt mode: any read or power down entry clears alert and flag.
// - comparator alert holds until depth conversions below hysteresis.
`timescale 1ns/1ps
module tmr_core
   import tmr_pkg::*;
#(
   parameter logic [6:0] SLAVE_ADDR = 7'h2a  // arbitrary value
)(
   input  wire logic       core_clk,
   input  wire logic       reset,
   input  wire logic       ce,
   input  wire logic       scl_in,
   input  wire logic       sda_in,
   output logic            sda_out,
   output logic            sda_oe,
   output logic            alert_out,
   output logic            alert_oe,
   input  wire logic       conv_done,
   input  wire logic [8:0] conv_internal,
   input  wire logic [8:0] conv_remote,
   output logic            zone_remote,
   output logic            power_down_select
);

   typedef struct packed {
      logic [2:0] scl_s;
      logic [2:0] sda_s;
      logic       scl_f;
      logic       sda_f;
      tmr_bus_t   st;
      logic [3:0] cnt;
      logic [7:0] sr;
      logic       rw;
      logic [1:0] ptr;
      logic       byte_hi;
      logic [7:0] hold;
      logic [8:0] temp;
      logic [8:0] hysteresis_threshold;
      logic [8:0] setpoint;
      logic [7:0] cfg;
      logic [2:0] ovr_cnt;
      logic [2:0] und_cnt;
      logic       alert_act;
      logic       armed_over;
      logic       sda_oe;
      logic       alert_oe;
      logic       drv_lvl;
   } tmr_state_t;

   tmr_state_t r;
   tmr_state_t n;
   logic       scl_rise;
   logic       scl_fall;
   logic       start;
   logic       stop;
   logic       rd_evt;
   logic       load;
   logic       clr_any;
   logic       clr_flag;
   logic [8:0] t;
   logic       ov;
   logic       un;
   logic       ovq;
   logic       unq;
   logic [2:0] dep;

   function automatic logic [2:0] depth_of(input logic [1:0] d);
      case (d)
         2'h0:    depth_of = DEPTH_1;
         2'h1:    depth_of = DEPTH_2;
         2'h2:    depth_of = DEPTH_4;
         default: depth_of = DEPTH_6;
      endcase
   endfunction

   function automatic logic [2:0] sat_inc(input logic [2:0] c);
      sat_inc = (c >= DEPTH_6) ? DEPTH_6 : c + 3'h1;
   endfunction

   function automatic logic [7:0] rd_byte(input tmr_state_t s);
      logic [8:0] v;
      case (s.ptr)
         PTR_TEMP: v = s.temp;
         PTR_HYST: v = s.hysteresis_threshold;
         default:  v = s.setpoint;
      endcase
      if (s.ptr == PTR_CFG)
         rd_byte = s.cfg;
      else if (s.byte_hi)
         rd_byte = v[8:1];
      else
         rd_byte = {v[0], 7'h00};
   endfunction

   always_comb
   begin
      n        = r;
      rd_evt   = 1'b0;
      load     = 1'b0;
      n.scl_s  = {r.scl_s[1:0], scl_in};
      n.sda_s  = {r.sda_s[1:0], sda_in};
      // a level counts only once the second and third stage agree
      if (r.scl_s[2] == r.scl_s[1])
         n.scl_f = r.scl_s[2];
      if (r.sda_s[2] == r.sda_s[1])
         n.sda_f = r.sda_s[2];
      scl_rise = ~r.scl_f & n.scl_f;
      scl_fall = r.scl_f & ~n.scl_f;
      start    = r.scl_f & n.scl_f & r.sda_f & ~n.sda_f;
      stop     = r.scl_f & n.scl_f & ~r.sda_f & n.sda_f;
      if (start)
      begin
         n.st     = S_ADDR;
         n.cnt    = 4'h0;
         n.sda_oe = 1'b0;
      end
      else if (stop)
      begin
         n.st     = S_IDLE;
         n.sda_oe = 1'b0;
      end
      else if (scl_rise)
      begin
         case (r.st)
            S_ADDR, S_CMD, S_WR:
            begin
               n.sr  = {r.sr[6:0], n.sda_f};
               n.cnt = r.cnt + 4'h1;
            end
            S_RD:
               n.cnt = r.cnt + 4'h1;
            S_RACK:
               if (n.sda_f)
                  n.st = S_IDLE;
            default:
               n.st = r.st;
         endcase
      end
      else if (scl_fall)
      begin
         case (r.st)
            S_ADDR:
               if (r.cnt == BYTE_BITS)
               begin
                  if (r.sr[7:1] == SLAVE_ADDR)
                  begin
                     n.st      = S_AACK;
                     n.sda_oe  = 1'b1;
                     n.rw      = r.sr[0];
                     n.byte_hi = 1'b1;
                  end
                  else
                     n.st = S_IDLE;
               end
            S_CMD:
               if (r.cnt == BYTE_BITS)
               begin
                  n.ptr     = r.sr[1:0];
                  n.st      = S_CACK;
                  n.sda_oe  = 1'b1;
               end
            S_WR:
               if (r.cnt == BYTE_BITS)
               begin
                  n.st     = S_WACK;
                  n.sda_oe = 1'b1;
                  if (r.ptr == PTR_CFG)
                     n.cfg[6:0] = r.sr[6:0];
                  else if (r.ptr != PTR_TEMP)
                  begin
                     if (r.byte_hi)
                     begin
                        n.hold    = r.sr;
                        n.byte_hi = 1'b0;
                     end
                     else
                     begin
                        // low seven bits of the second byte are dropped
                        if (r.ptr == PTR_HYST)
                           n.hysteresis_threshold = {r.hold, r.sr[7]};
                        else
                           n.setpoint = {r.hold, r.sr[7]};
                        n.byte_hi = 1'b1;
                     end
                  end
               end
            S_AACK:
            begin
               n.cnt = 4'h0;
               // read event at the first load, so a config read still shows the flag
               if (r.rw)
               begin
                  load   = 1'b1;
                  rd_evt = 1'b1;
               end
               else
               begin
                  n.st     = S_CMD;
                  n.sda_oe = 1'b0;
               end
            end
            S_CACK, S_WACK:
            begin
               n.st     = S_WR;
               n.cnt    = 4'h0;
               n.sda_oe = 1'b0;
            end
            S_RD:
               if (r.cnt == BYTE_BITS)
               begin
                  n.st     = S_RACK;
                  n.sda_oe = 1'b0;
               end
               else
               begin
                  n.sr     = {r.sr[6:0], 1'b0};
                  n.sda_oe = ~r.sr[6];
               end
            S_RACK:
               load = 1'b1;
            default:
               n.st = r.st;
         endcase
      end
      if (load)
      begin
         n.st      = S_RD;
         n.cnt     = 4'h0;
         n.sr      = rd_byte(r);
         n.sda_oe  = ~n.sr[7];
         n.byte_hi = (r.ptr == PTR_CFG) | ~r.byte_hi;
      end

      // clears come first so that a conversion in the same cycle wins
      clr_any  = r.cfg[CFG_MODE] & (rd_evt | (~r.cfg[CFG_PDN] & n.cfg[CFG_PDN]));
      clr_flag = clr_any | (rd_evt & (r.ptr == PTR_CFG));
      if (clr_flag)
         n.cfg[CFG_FLAG] = 1'b0;
      if (clr_any)
         n.alert_act = 1'b0;
      if (!n.cfg[CFG_MODE])
         n.armed_over = 1'b1;  // leaving interrupt mode re-arms for overtemperature

      t   = r.cfg[CFG_ZONE] ? conv_remote : conv_internal;
      ov  = $signed(t) > $signed(r.setpoint);
      un  = $signed(t) < $signed(r.hysteresis_threshold);
      dep = depth_of(r.cfg[CFG_DEPH:CFG_DEPL]);
      ovq = 1'b0;
      unq = 1'b0;
      if (conv_done & ~r.cfg[CFG_PDN])
      begin
         n.temp    = t;
         n.ovr_cnt = ov ? sat_inc(r.ovr_cnt) : 3'h0;
         n.und_cnt = un ? sat_inc(r.und_cnt) : 3'h0;
         ovq       = ov & (n.ovr_cnt >= dep);
         unq       = un & (n.und_cnt >= dep);
         if (r.cfg[CFG_MODE])
         begin
            if (ovq & n.armed_over)
            begin
               n.cfg[CFG_FLAG] = 1'b1;
               n.alert_act     = 1'b1;
               n.armed_over    = 1'b0;
            end
            else if (unq & ~n.armed_over)
            begin
               n.cfg[CFG_FLAG] = 1'b1;
               n.alert_act     = 1'b1;
               n.armed_over    = 1'b1;
            end
         end
         else
         begin
            if (ovq | unq)
               n.cfg[CFG_FLAG] = 1'b1;
            if (ovq)
               n.alert_act = 1'b1;
            else if (unq)
               n.alert_act = 1'b0;
         end
      end
      // open drain: enable means pulling the pin low
      n.alert_oe = ~n.cfg[CFG_MASK]
                 & (n.cfg[CFG_ALPOL] ? ~n.alert_act : n.alert_act);
      n.drv_lvl  = 1'b0;
   end

   always_ff @(posedge core_clk or posedge reset)
   begin
      if (reset)
      begin
         r                      <= '0;
         r.scl_s                <= 3'h7;
         r.sda_s                <= 3'h7;
         r.scl_f                <= 1'b1;
         r.sda_f                <= 1'b1;
         r.st                   <= S_IDLE;
         r.temp                 <= TEMP_RST;
         r.hysteresis_threshold <= HYST_RST;
         r.setpoint             <= SET_RST;
         r.cfg                  <= CFG_RST;
         r.armed_over           <= 1'b1;
      end
      else if (ce)
         r <= n;
   end

   assign sda_out           = r.drv_lvl;
   assign sda_oe            = r.sda_oe;
   assign alert_out         = r.drv_lvl;
   assign alert_oe          = r.alert_oe;
   assign zone_remote       = r.cfg[CFG_ZONE];
   assign power_down_select = r.cfg[CFG_PDN];

   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (reset);

   AST_CMD_SELECT: assert property (
      (ce && r.st == S_CMD && scl_fall && !start && !stop && r.cnt == BYTE_BITS)
      |=> r.ptr == $past(r.sr[1:0]))
      else $error("command byte did not select the register");
   AST_TEMP_RO: assert property (
      (!conv_done) |=> $stable(r.temp))
      else $error("temperature changed without a conversion");
   AST_FLAG_CAUSE: assert property (
      $rose(r.cfg[CFG_FLAG]) |-> $past(conv_done))
      else $error("event flag set without a conversion");
   AST_MASK_HIZ: assert property (
      r.cfg[CFG_MASK] |-> !alert_oe)
      else $error("alert driven while masked");
   AST_POLARITY: assert property (
      !r.cfg[CFG_MASK] |-> alert_oe == (r.alert_act ^ r.cfg[CFG_ALPOL]))
      else $error("alert pin level disagrees with polarity");
   AST_READ_CLEARS: assert property (
      (ce && rd_evt && r.cfg[CFG_MODE] && !conv_done) |=> !r.alert_act && !r.cfg[CFG_FLAG])
      else $error("interrupt mode read did not clear alert");
   AST_DEPTH: assert property (
      ($rose(r.alert_act) && !r.cfg[CFG_MODE])
      |-> r.ovr_cnt >= depth_of($past(r.cfg[CFG_DEPH:CFG_DEPL])))
      else $error("alert asserted before filter depth reached");
   AST_ZONE: assert property (
      (ce && conv_done && !r.cfg[CFG_PDN] && r.cfg[CFG_ZONE])
      |=> r.temp == $past(conv_remote))
      else $error("remote zone result not captured");
   AST_CMP_HOLD: assert property (
      (!r.cfg[CFG_MODE] && r.alert_act && !conv_done) |=> r.alert_act)
      else $error("comparator alert dropped without a conversion");

endmodule

// *** hw/tmr_pkg.sv ***
// tmr_pkg: register map, field positions and reset values of the temperature monitor
// assumes: imported by the monitor core and its test bench; 9-bit values are two's complement
package tmr_pkg;
   localparam logic [1:0] PTR_TEMP = 2'h0;
   localparam logic [1:0] PTR_CFG  = 2'h1;
   localparam logic [1:0] PTR_HYST = 2'h2;
   localparam logic [1:0] PTR_SET  = 2'h3;
   localparam int CFG_FLAG  = 7;
   localparam int CFG_MASK  = 6;
   localparam int CFG_ZONE  = 5;
   localparam int CFG_DEPH  = 4;
   localparam int CFG_DEPL  = 3;
   localparam int CFG_ALPOL = 2;
   localparam int CFG_MODE  = 1;
   localparam int CFG_PDN   = 0;
   localparam logic [8:0] TEMP_RST = 9'h000;
   localparam logic [8:0] HYST_RST = 9'h096;
   localparam logic [8:0] SET_RST  = 9'h0a0;
   localparam logic [7:0] CFG_RST  = 8'h00;
   localparam logic [3:0] BYTE_BITS = 4'h8;
   localparam logic [2:0] DEPTH_1 = 3'h1;
   localparam logic [2:0] DEPTH_2 = 3'h2;
   localparam logic [2:0] DEPTH_4 = 3'h4;
   localparam logic [2:0] DEPTH_6 = 3'h6;
   typedef enum logic [3:0] {
      S_IDLE, S_ADDR, S_AACK, S_CMD, S_CACK, S_WR, S_WACK, S_RD, S_RACK
   } tmr_bus_t;
endpackage

// *** test/tmr_host.sv ***
// tmr_host: behavioural two-wire host that reads and writes the monitor registers
// assumes: tasks are entered at a core clock fall; the data line has a pull-up
`timescale 1ns/1ps
module tmr_host #(
   parameter logic [6:0] ADDR = 7'h2a  // arbitrary value
)(
   output logic     scl,
   output logic     sda_drv,
   input  wire logic sda_line
);
   int nak_count;
   initial
   begin
      scl = 1'b1;
      sda_drv = 1'b1;
      nak_count = 0;
   end
   // clock stands high between frames; data moves only while clock is low
   task automatic bit_io(input logic b, output logic r);
      #200 sda_drv = b;
      #300 scl = 1'b1;
      #200 r = sda_line;
      #100 scl = 1'b0;
   endtask
   task automatic xfer(input logic [7:0] tx, input logic ninth, input logic wr,
                       output logic [7:0] rx);
      logic a;
      for (int i = 7; i >= 0; i--)
         bit_io(tx[i], rx[i]);
      bit_io(ninth, a);
      if (wr)
         nak_count += int'(a);
   endtask
   task automatic stop();
      #200 sda_drv = 1'b0;
      #300 scl = 1'b1;
      #300 sda_drv = 1'b1;
      #400;
   endtask
   task automatic pointer(input logic [1:0] ptr);
      logic [7:0] rx;
      sda_drv = 1'b0;
      #400 scl = 1'b0;
      xfer({ADDR, 1'b0}, 1'b1, 1'b1, rx);
      xfer({6'h00, ptr}, 1'b1, 1'b1, rx);
   endtask
   // nine-bit values go out as two bytes, left justified, low bits zero
   task automatic wr_reg(input logic [1:0] ptr, input logic [15:0] d, input logic two);
      logic [7:0] rx;
      pointer(ptr);
      xfer(d[15:8], 1'b1, 1'b1, rx);
      if (two)
         xfer(d[7:0], 1'b1, 1'b1, rx);
      stop();
   endtask
   // repeated start, two bytes, last one refused by the host
   task automatic rd_reg(input logic [1:0] ptr, output logic [15:0] d);
      pointer(ptr);
      #200 sda_drv = 1'b1;
      #300 scl = 1'b1;
      #300 sda_drv = 1'b0;
      #200 scl = 1'b0;
      xfer({ADDR, 1'b1}, 1'b1, 1'b1, d[7:0]);
      xfer(8'hff, 1'b0, 1'b0, d[15:8]);
      xfer(8'hff, 1'b1, 1'b0, d[7:0]);
      stop();
   endtask
endmodule

// *** test/tmr_core_test.sv ***
// tmr_core_test: self-checking bench for the monitor register set
// assumes: host model drives the serial pins; conversions are fed directly
`timescale 1ns/1ps
module tmr_core_test;
   import tmr_pkg::*;
   localparam logic [15:0] RST_VAL [4] = '{{TEMP_RST, 7'h00}, {CFG_RST, CFG_RST},
                                          {HYST_RST, 7'h00}, {SET_RST, 7'h00}};
   localparam logic [7:0]  PM_CFG [5]  = '{8'h04, 8'h44, 8'h44, 8'h04, 8'h00};
   logic        core_clk;
   logic        reset;
   logic        scl;
   logic        sda_drv;
   logic        sda_line;
   logic        sda_out;
   logic        sda_oe;
   logic        alert_out;
   logic        alert_oe;
   logic        conv_done;
   logic [8:0]  conv_internal;
   logic [8:0]  conv_remote;
   logic        zone_remote;
   logic        power_down_select;
   logic [31:0] seed;
   logic [15:0] d;
   logic [8:0]  v;
   int          fails;
   int          num_checks;
   assign sda_line = sda_drv & ~sda_oe;
   tmr_host i_host(.scl(scl), .sda_drv(sda_drv), .sda_line(sda_line));
   tmr_core i_dut(.core_clk(core_clk), .reset(reset), .ce(1'b1), .scl_in(scl),
      .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe), .alert_out(alert_out),
      .alert_oe(alert_oe), .conv_done(conv_done), .conv_internal(conv_internal),
      .conv_remote(conv_remote), .zone_remote(zone_remote),
      .power_down_select(power_down_select));
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] t;
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      return t ^ (t << 5);
   endfunction
   function automatic int depth_of(input logic [1:0] c);
      return (c == 2'h0) ? 1 : int'(c) * 2;
   endfunction
   // alert_oe high means the pin is pulled low
   function automatic logic exp_oe(input logic act, input logic [7:0] cfg);
      return !cfg[CFG_MASK] && (act ^ cfg[CFG_ALPOL]);
   endfunction
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         fails++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic conv(input logic [8:0] vi, input logic [8:0] vr, input int n);
      repeat (n)
      begin
         @(negedge core_clk);
         conv_done = 1'b1;
         conv_internal = vi;
         conv_remote = vr;
         @(negedge core_clk);
         conv_done = 1'b0;
      end
      @(negedge core_clk);
   endtask
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial
   begin
      core_clk = 1'b0;
      forever #50 core_clk = ~core_clk;
   end
   // whole run needs about 1.9 ms of bus traffic
   initial
   begin
      #8000000;
      fails++;
      print_verdict();
   end
   initial
   begin
      reset = 1'b1;
      conv_done = 1'b0;
      conv_internal = 9'h000;
      conv_remote = 9'h000;
      seed = 32'd24;
      fails = 0;
      num_checks = 0;
      repeat (4) @(negedge core_clk);
      reset = 1'b0;
      repeat (4) @(negedge core_clk);
      for (int i = 0; i < 4; i++)
      begin
         i_host.rd_reg(2'(i), d);
         check("reset value", d, RST_VAL[i]);
      end
      repeat (3)
      begin
         seed = xs(seed);
         v = seed[8:0];
         i_host.wr_reg(PTR_HYST, {v, 7'h00}, 1'b1);
         i_host.wr_reg(PTR_SET, {~v, 7'h00}, 1'b1);
         i_host.wr_reg(PTR_TEMP, {~v, 7'h00}, 1'b1);
         i_host.wr_reg(PTR_SET, 16'h7f00, 1'b0);
         i_host.rd_reg(PTR_HYST, d);
         check("hyst", d, {v, 7'h00});
         i_host.rd_reg(PTR_SET, d);
         check("set", d, {~v, 7'h00});
         i_host.rd_reg(PTR_TEMP, d);
         check("temp ro", d, 16'h0000);
      end
      i_host.wr_reg(PTR_HYST, {9'h010, 7'h00}, 1'b1);
      i_host.wr_reg(PTR_SET, {9'h020, 7'h00}, 1'b1);
      for (int c = 0; c < 4; c++)
      begin
         i_host.wr_reg(PTR_CFG, {3'h0, 2'(c), 3'h0, 8'h00}, 1'b0);
         seed = xs(seed);
         v = 9'h021 + 9'(seed[6:0]);
         conv(v, 9'h000, depth_of(2'(c)) - 1);
         i_host.rd_reg(PTR_CFG, d);
         check("early flag", 16'(d[15]), 16'h0);
         check("early alert", 16'(alert_oe), 16'h0);
         conv(v, 9'h000, 1);
         check("alert", 16'(alert_oe), 16'h1);
         i_host.rd_reg(PTR_TEMP, d);
         check("temp", d, {v, 7'h00});
         conv(9'h1f0, 9'h000, depth_of(2'(c)) - 1);
         check("alert held", 16'(alert_oe), 16'h1);
         conv(9'h1f0, 9'h000, 1);
         check("alert off", 16'(alert_oe), 16'h0);
         i_host.rd_reg(PTR_CFG, d);
         check("flag", 16'(d[15:8]), 16'({1'b1, 2'h0, 2'(c), 3'h0}));
      end
      for (int k = 0; k < 5; k++)
      begin
         if (k == 2)
            conv(9'h0ff, 9'h000, 1);
         i_host.wr_reg(PTR_CFG, {PM_CFG[k], 8'h00}, 1'b0);
         check("alert pin", 16'(alert_oe), 16'(exp_oe(k >= 2, PM_CFG[k])));
      end
      conv(9'h1f0, 9'h000, 1);
      i_host.wr_reg(PTR_CFG, 16'h0200, 1'b0);
      i_host.rd_reg(PTR_CFG, d);
      conv(9'h0ff, 9'h000, 1);
      check("int alert", 16'(alert_oe), 16'h1);
      i_host.rd_reg(PTR_TEMP, d);
      check("int read clr", 16'(alert_oe), 16'h0);
      i_host.rd_reg(PTR_CFG, d);
      check("int flag clr", 16'(d[15]), 16'h0);
      conv(9'h1f0, 9'h000, 1);
      check("int under", 16'(alert_oe), 16'h1);
      i_host.wr_reg(PTR_CFG, 16'h0300, 1'b0);
      check("pdn clr", {14'h0, power_down_select, alert_oe}, 16'h0002);
      conv(9'h055, 9'h000, 1);
      i_host.rd_reg(PTR_TEMP, d);
      check("pdn temp", d, {9'h1f0, 7'h00});
      i_host.wr_reg(PTR_CFG, 16'ha000, 1'b0);
      i_host.rd_reg(PTR_CFG, d);
      check("flag ro", 16'(d[15:8]), 16'h0020);
      seed = xs(seed);
      conv(9'h000, seed[8:0], 1);
      i_host.rd_reg(PTR_TEMP, d);
      check("zone", {d[15:7], 6'h0, zone_remote}, {seed[8:0], 7'h01});
      check("acks", 16'(i_host.nak_count), 16'h0000);
      check("drive levels", {14'h0, sda_out, alert_out}, 16'h0000);
      print_verdict();
   end
endmodule
